// >>> include/fpp_pkg.sv
// shared constants, carrier structs and state codes for the parallel / local bus port
package fpp_pkg;

	// clock and timing base
	localparam int CLK_MHZ = 250;
	localparam int TICK_NS = 40;
	// cycles per timing tick, rounded up so every phase is at least as long as asked
	localparam int TICK_CYC = (TICK_NS * CLK_MHZ + 999) / 1000;

	// phase lengths in ticks
	localparam int SETUP_TICKS = 1;
	localparam int STROBE_TICKS = 2;
	localparam int HOLD_TICKS = 1;
	// longest wait for the enhanced-mode handshake, rounded down to whole ticks
	localparam int WAIT_TIMEOUT_NS = 10000;
	localparam int WAIT_TIMEOUT_TICKS = WAIT_TIMEOUT_NS / TICK_NS;
	localparam int TICK_CNT_W = 8;

	// widths and depths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int RSP_DEPTH = 2;

	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

	// one access request from the user side
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpp_cmd_t;

	// sampled peripheral status lines
	typedef struct packed {
		logic paperOut;
		logic selected;
		logic errorActive;
		logic busy;
	} fpp_status_t;

	localparam fpp_status_t STATUS_RST = 4'h0;

	// target of the access in flight
	typedef enum logic [1:0] {
		K_LOCAL = 2'h0,
		K_SPP = 2'h1,
		K_EPP = 2'h2
	} fpp_kind_t;

	// access sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_STROBE = 4'h4,
		ST_FINISH = 4'h8
	} fpp_state_t;

endpackage

// >>> core/fpp_tick_div.sv
// divider that gives a one-cycle timing tick every DIV clocks
`timescale 1ns/10ps
module fpp_tick_div import fpp_pkg::*; #(
	parameter int DIV = TICK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clear,
	output logic tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cntQ;

	// restart on clear so a phase never starts part way into a tick
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clear) begin
			cntQ <= '0;
		end else if (cntQ == LAST) begin
			cntQ <= '0;
		end else begin
			cntQ <= cntQ + 1'b1;
		end
	end

	assign tick = (cntQ == LAST) && !clear;

endmodule

// >>> core/fpp_skid_buf.sv
// small valid/ready buffer for read answers
`timescale 1ns/10ps
module fpp_skid_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] memQ [DEPTH];
	logic [PW-1:0] wrPtrQ;
	logic [PW-1:0] rdPtrQ;
	logic [PW:0] countQ;
	logic push;
	logic pop;

	assign inReady = (countQ != FULL);
	assign outValid = (countQ != '0);
	assign outData = memQ[rdPtrQ];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	// storage, written only on an accepted push
	always_ff @(posedge clk_sys) begin
		if (push) begin
			memQ[wrPtrQ] <= inData;
		end
	end

	// pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wrPtrQ <= '0;
			rdPtrQ <= '0;
		end else begin
			if (push) begin
				wrPtrQ <= (wrPtrQ == LAST) ? '0 : wrPtrQ + 1'b1;
			end
			if (pop) begin
				rdPtrQ <= (rdPtrQ == LAST) ? '0 : rdPtrQ + 1'b1;
			end
		end
	end

	// fill level gives honest full and empty
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			countQ <= '0;
		end else if (push && !pop) begin
			countQ <= countQ + 1'b1;
		end else if (pop && !push) begin
			countQ <= countQ - 1'b1;
		end
	end

endmodule

// >>> core/fpp_port_core.sv
// parallel port and 8-bit local bus pin engine of the second function
//
// Notes on behaviour
// - enhanced-mode interrupt equals acknowledge line
// - enhanced mode: busy pin is wait handshake
// - standard mode: drive select-in low to select
// - initialise output same in both modes
// - standard mode: auto-feed is open-drain output
// - enhanced mode: auto-feed pin is data strobe
// - standard mode: strobe pulsed over valid data
// - enhanced mode: strobe pin is write direction
// - separate-strobe mode: read strobe on reads
// - data-strobe style: read strobe pin undriven
// - drive eight-bit local address per access
// - local data lines are bidirectional
// - direction output high while driving data
// - write strobe, or read-not-write in data-strobe style
`timescale 1ns/10ps
module fpp_port_core import fpp_pkg::*; #(
	parameter int SETUP_T = SETUP_TICKS,
	parameter int STROBE_T = STROBE_TICKS,
	parameter int HOLD_T = HOLD_TICKS,
	parameter int TIMEOUT_T = WAIT_TIMEOUT_TICKS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	// static configuration
	input wire logic portIsParallel,
	input wire logic lbDataStrobeStyle,
	input wire logic parIsEpp,
	input wire logic selectPeripheral,
	input wire logic initPeripheral,
	input wire logic autoFeed,
	// access requests
	input wire logic cmdValid,
	output logic cmdReady,
	input wire fpp_cmd_t cmd,
	// read answers
	output logic rspValid,
	input wire logic rspReady,
	output logic [DATA_W-1:0] rspData,
	// status toward the user
	output fpp_status_t status,
	output logic ackEvent,
	output logic eppIrq,
	output logic cycleTimeout,
	// parallel port pins
	input wire logic ackN,
	input wire logic paperOutStatus,
	input wire logic busy,
	input wire logic peripheralSelected,
	input wire logic errorN,
	output logic hostSelectInN,
	output logic initN,
	output logic autoFeedNOut,
	output logic autoFeedNOe,
	output logic sppDataStrobeN,
	input wire logic [DATA_W-1:0] parallelDataIn,
	output logic [DATA_W-1:0] parallelDataOut,
	output logic parallelDataOe,
	// local bus pins
	output logic [ADDR_W-1:0] localAddress,
	input wire logic [DATA_W-1:0] localDataIn,
	output logic [DATA_W-1:0] localDataOut,
	output logic localDataOe,
	output logic localDataDirOut,
	output logic localReadStrobeNOut,
	output logic localReadStrobeNOe,
	output logic localWriteStrobeN
);

	fpp_state_t stateQ;
	fpp_kind_t kindQ;
	fpp_kind_t cmdKind;
	fpp_cmd_t curQ;
	fpp_status_t statusQ;
	logic [TICK_CNT_W-1:0] tickCntQ;
	logic phaseClrQ;
	logic tick;
	logic pushQ;
	logic [DATA_W-1:0] rdDataQ;
	logic bufInReady;
	logic ackQ;
	logic ackPrevQ;
	logic busOn;
	logic strobeOn;
	logic eppStrobeN;
	logic parDataOeQ;
	logic localDataOeQ;
	logic [ADDR_W-1:0] localAddressQ;

	// true once the tick count of the current phase has reached its limit
	function automatic logic reached(input logic [TICK_CNT_W-1:0] cnt, input int lim);
		reached = (cnt >= TICK_CNT_W'(lim));
	endfunction

	fpp_tick_div #(
		.DIV(TICK_CYC)
	) uTick (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clear(phaseClrQ),
		.tick(tick)
	);

	// answers wait here, RSP_DEPTH deep, until a slow reader takes them
	fpp_skid_buf #(
		.WIDTH(DATA_W),
		.DEPTH(RSP_DEPTH)
	) uRsp (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.inValid(pushQ),
		.inReady(bufInReady),
		.inData(rdDataQ),
		.outValid(rspValid),
		.outReady(rspReady),
		.outData(rspData)
	);

	// which pins the request will use
	always_comb begin
		if (!portIsParallel) begin
			cmdKind = K_LOCAL;
		end else if (parIsEpp) begin
			cmdKind = K_EPP;
		end else begin
			cmdKind = K_SPP;
		end
	end

	// a read is only taken while the answer buffer has a free slot, but the check does not count a push still
	// in flight, so a read taken in that cycle can find the buffer full at the end of its access
	assign cmdReady = (stateQ == ST_IDLE) && (cmd.write || bufInReady)
		&& !(cmdKind == K_SPP && cmd.write && statusQ.busy);

	assign busOn = (stateQ != ST_IDLE);
	assign strobeOn = (stateQ == ST_STROBE);

	// status pins are sampled every cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			statusQ <= STATUS_RST;
		end else begin
			statusQ.paperOut <= paperOutStatus;
			statusQ.selected <= peripheralSelected;
			statusQ.errorActive <= !errorN;
			statusQ.busy <= busy;
		end
	end

	assign status = statusQ;

	// acknowledge falling edge marks a completed transfer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ackQ <= 1'b1;
			ackPrevQ <= 1'b1;
			ackEvent <= 1'b0;
			eppIrq <= 1'b0;
		end else begin
			ackQ <= ackN;
			ackPrevQ <= ackQ;
			ackEvent <= ackPrevQ && !ackQ;
			eppIrq <= parIsEpp && !ackQ;
		end
	end

	// access sequencer: setup, strobe, finish, timed in ticks; enhanced strobe and finish end on wait or on the tick timeout
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			stateQ <= ST_IDLE;
			kindQ <= K_LOCAL;
			curQ <= '0;
			tickCntQ <= '0;
			phaseClrQ <= 1'b0;
			pushQ <= 1'b0;
			rdDataQ <= DATA_RST;
			cycleTimeout <= 1'b0;
		end else begin
			phaseClrQ <= 1'b0;
			pushQ <= 1'b0;
			cycleTimeout <= 1'b0;
			if (tick && !reached(tickCntQ, TIMEOUT_T)) begin
				tickCntQ <= tickCntQ + 1'b1;
			end
			unique case (stateQ)
				ST_IDLE: begin
					if (cmdValid && cmdReady) begin
						curQ <= cmd;
						kindQ <= cmdKind;
						stateQ <= ST_SETUP;
						phaseClrQ <= 1'b1;
						tickCntQ <= '0;
					end
				end
				ST_SETUP: begin
					if (reached(tickCntQ, SETUP_T)) begin
						stateQ <= ST_STROBE;
						phaseClrQ <= 1'b1;
						tickCntQ <= '0;
					end
				end
				ST_STROBE: begin
					if (kindQ == K_EPP) begin
						// strobe stays low until wait goes high; a dead peripheral times out
						if (statusQ.busy || reached(tickCntQ, TIMEOUT_T)) begin
							rdDataQ <= parallelDataIn;
							cycleTimeout <= !statusQ.busy;
							stateQ <= ST_FINISH;
							phaseClrQ <= 1'b1;
							tickCntQ <= '0;
						end
					end else if (reached(tickCntQ, STROBE_T)) begin
						rdDataQ <= (kindQ == K_LOCAL) ? localDataIn : parallelDataIn;
						stateQ <= ST_FINISH;
						phaseClrQ <= 1'b1;
						tickCntQ <= '0;
					end
				end
				ST_FINISH: begin
					// enhanced cycles end when the peripheral drops wait again
					if ((kindQ == K_EPP) ? (!statusQ.busy || reached(tickCntQ, TIMEOUT_T))
						: reached(tickCntQ, HOLD_T)) begin
						cycleTimeout <= (kindQ == K_EPP) && statusQ.busy;
						pushQ <= !curQ.write;
						stateQ <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// local bus pins, all from flops so no glitches reach the peripherals
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			localAddressQ <= ADDR_RST;
			localDataOut <= DATA_RST;
			localDataOeQ <= 1'b0;
			localReadStrobeNOut <= 1'b1;
			localReadStrobeNOe <= 1'b0;
			localWriteStrobeN <= 1'b1;
		end else begin
			if (busOn && kindQ == K_LOCAL) begin
				localAddressQ <= curQ.addr;
			end
			localDataOut <= curQ.data;
			localDataOeQ <= busOn && kindQ == K_LOCAL && curQ.write;
			localReadStrobeNOut <= !(strobeOn && kindQ == K_LOCAL && !curQ.write
				&& !lbDataStrobeStyle);
			localReadStrobeNOe <= !lbDataStrobeStyle;
			if (lbDataStrobeStyle) begin
				// read-not-write level for the whole access, high when idle
				localWriteStrobeN <= !(busOn && kindQ == K_LOCAL && curQ.write);
			end else begin
				localWriteStrobeN <= !(strobeOn && kindQ == K_LOCAL && curQ.write);
			end
		end
	end

	assign localAddress = localAddressQ;
	assign localDataOe = localDataOeQ;
	assign localDataDirOut = localDataOeQ;

	// parallel port pins
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			parallelDataOut <= DATA_RST;
			parDataOeQ <= 1'b0;
			sppDataStrobeN <= 1'b1;
			eppStrobeN <= 1'b1;
			hostSelectInN <= 1'b1;
			initN <= 1'b1;
			autoFeedNOe <= 1'b0;
		end else begin
			parallelDataOut <= curQ.data;
			parDataOeQ <= busOn && kindQ != K_LOCAL && curQ.write;
			if (parIsEpp) begin
				// direction: low for writes, high for reads and idle
				sppDataStrobeN <= !(busOn && kindQ == K_EPP && curQ.write);
			end else begin
				// data already stable for a setup phase before the pulse
				sppDataStrobeN <= !(strobeOn && kindQ == K_SPP && curQ.write);
			end
			eppStrobeN <= !(strobeOn && kindQ == K_EPP);
			hostSelectInN <= parIsEpp || !selectPeripheral;
			initN <= !initPeripheral;
			autoFeedNOe <= parIsEpp || autoFeed;
		end
	end

	assign parallelDataOe = parDataOeQ;
	// open-drain in standard mode only ever pulls low; enhanced mode drives the strobe
	assign autoFeedNOut = parIsEpp ? eppStrobeN : 1'b0;

endmodule

// >>> verification/fpp_port_core_asserts.sv
// pin timing checks for the port engine
`timescale 1ns/10ps
module fpp_port_core_asserts import fpp_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic lbDataStrobeStyle,
	input wire logic parIsEpp,
	input wire logic selectPeripheral,
	input wire logic initPeripheral,
	input wire logic ackN,
	input wire logic busy,
	input wire logic paperOutStatus,
	input wire logic peripheralSelected,
	input wire logic errorN,
	input wire fpp_status_t status,
	input wire logic eppIrq,
	input wire logic hostSelectInN,
	input wire logic initN,
	input wire logic autoFeedNOut,
	input wire logic sppDataStrobeN,
	input wire logic parallelDataOe,
	input wire logic localDataOe,
	input wire logic localDataDirOut,
	input wire logic localReadStrobeNOut,
	input wire logic localReadStrobeNOe,
	input wire logic localWriteStrobeN
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_dir_pin: assert property (localDataDirOut == localDataOe)
		else $error("direction pin off");
	a_rd_hiz: assert property ($past(lbDataStrobeStyle) |-> !localReadStrobeNOe)
		else $error("read strobe driven");
	a_init_out: assert property ($past(rst_n) |-> initN == !$past(initPeripheral))
		else $error("init pin wrong");
	a_sel_out: assert property ($past(rst_n) && parIsEpp == $past(parIsEpp)
		|-> hostSelectInN == !($past(selectPeripheral) && !parIsEpp))
		else $error("select pin wrong");
	a_feed_od: assert property ($past(rst_n) && !parIsEpp && !$past(parIsEpp) |-> !autoFeedNOut)
		else $error("feed pin drives high");
	a_wr_data: assert property (!lbDataStrobeStyle && !localWriteStrobeN |-> localDataOe)
		else $error("write strobe without data");
	a_rd_quiet: assert property (!localReadStrobeNOut |-> !localDataOe && localReadStrobeNOe)
		else $error("read strobe while driving");
	a_spp_data: assert property (!parIsEpp && !sppDataStrobeN |-> parallelDataOe)
		else $error("strobe without data");
	a_epp_dir: assert property (parIsEpp && !autoFeedNOut |-> sppDataStrobeN == !parallelDataOe)
		else $error("direction and data disagree");
	a_epp_hold: assert property (parIsEpp && !autoFeedNOut && !busy |=> !autoFeedNOut)
		else $error("data strobe dropped early");
	a_irq_out: assert property ($past(rst_n) && $past(rst_n, 2) && parIsEpp && $past(parIsEpp)
		&& $past(parIsEpp, 2) |-> eppIrq == !$past(ackN, 2))
		else $error("irq does not follow");
	a_status: assert property ($past(rst_n) |-> status == {$past(paperOutStatus),
		$past(peripheralSelected), !$past(errorN), $past(busy)})
		else $error("status not sampled");
endmodule

// >>> verification/fpp_peer_model.sv
// parallel peripheral: latches bytes, answers with busy, ack and read data
`timescale 1ns/10ps
module fpp_peer_model import fpp_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic eppMode,
	input wire logic slow,
	input wire logic irqReq,
	input wire logic [DATA_W-1:0] rdByte,
	input wire logic sppDataStrobeN,
	input wire logic autoFeedNOut,
	input wire logic [DATA_W-1:0] parallelDataOut,
	input wire logic parallelDataOe,
	output logic ackN,
	output logic busy,
	output logic [DATA_W-1:0] parallelDataIn,
	output logic [DATA_W-1:0] latched
);
	logic [5:0] cnt;
	logic stbQ;
	// in enhanced mode the released bus shows the inverse outside the data strobe, so a stale byte never matches
	assign parallelDataIn = parallelDataOe ? parallelDataOut :
		((!eppMode || !autoFeedNOut) ? rdByte : ~rdByte);
	// standard: busy then ack after strobe; enhanced: wait after a delay
	always_ff @(posedge clk_sys) begin
		stbQ <= sppDataStrobeN;
		if (!rst_n) begin
			cnt <= 6'h00;
			busy <= 1'b0;
			ackN <= 1'b1;
		end else if (!eppMode) begin
			if (stbQ && !sppDataStrobeN) begin
				latched <= parallelDataOut;
				cnt <= slow ? 6'h30 : 6'h08;
			end else if (cnt != 6'h00) begin
				cnt <= cnt - 6'h01;
			end
			busy <= cnt > 6'h04;
			ackN <= !(cnt != 6'h00 && cnt <= 6'h04);
		end else begin
			ackN <= !irqReq;
			if (autoFeedNOut) begin
				cnt <= slow ? 6'h0F : 6'h02;
				busy <= 1'b0;
			end else if (cnt != 6'h00) begin
				cnt <= cnt - 6'h01;
			end else begin
				busy <= 1'b1;
				if (!sppDataStrobeN) latched <= parallelDataOut;
			end
		end
	end
endmodule

// >>> verification/function1_parallel_and_local_bus_pins_tb_top.sv
// self-checking bench for the port engine
`timescale 1ns/10ps
module function1_parallel_and_local_bus_pins_tb_top import fpp_pkg::*;;
	typedef struct packed {logic par; logic ds; logic enhanced_parallel_mode; logic wr; logic [7:0] a; logic [7:0] d;} fpp_row_t;
	logic clk_sys, rst_n, portIsParallel, lbDataStrobeStyle, parIsEpp, selectPeripheral;
	logic initPeripheral, autoFeed, cmdValid, cmdReady, rspValid, rspReady, ackEvent, eppIrq;
	logic ackN, paperOutStatus, busy, peripheralSelected, errorN, hostSelectInN, initN;
	logic autoFeedNOut, autoFeedNOe, sppDataStrobeN, parallelDataOe, localDataOe, slow, irqReq;
	logic localDataDirOut, localReadStrobeNOut, localReadStrobeNOe, localWriteStrobeN;
	logic [7:0] rspData, parallelDataIn, parallelDataOut, localDataIn, localDataOut, localAddress;
	logic [7:0] latched, rdByte, local_read_strobe_n, capA, capD, got;
	fpp_cmd_t cmd;
	fpp_status_t status;
	logic peerBusy, stuck, timedOut;
	int failures, n_checks, n;
	int ackCnt = 0;
	int toCnt = 0;
	fpp_row_t rows [8];
	fpp_port_core #(.TIMEOUT_T(4)) dut (.clk_sys, .rst_n, .portIsParallel, .lbDataStrobeStyle,
		.parIsEpp, .selectPeripheral, .initPeripheral, .autoFeed, .cmdValid, .cmdReady, .cmd,
		.rspValid, .rspReady, .rspData, .status, .ackEvent, .eppIrq, .cycleTimeout(timedOut), .ackN,
		.paperOutStatus, .busy, .peripheralSelected, .errorN, .hostSelectInN, .initN,
		.autoFeedNOut, .autoFeedNOe, .sppDataStrobeN, .parallelDataIn, .parallelDataOut,
		.parallelDataOe, .localAddress, .localDataIn, .localDataOut, .localDataOe,
		.localDataDirOut, .localReadStrobeNOut, .localReadStrobeNOe, .localWriteStrobeN);
	fpp_peer_model peer (.clk_sys, .rst_n, .eppMode(parIsEpp), .slow, .irqReq, .rdByte,
		.sppDataStrobeN, .autoFeedNOut, .parallelDataOut, .parallelDataOe, .ackN, .busy(peerBusy),
		.parallelDataIn, .latched);
	// stuck stands for a peripheral that never releases wait, to reach the timeout
	assign busy = peerBusy || stuck;
	// local peripheral drives only while read is strobed (or always in data-strobe style)
	assign localDataIn = localDataOe ? localDataOut :
		((lbDataStrobeStyle || !localReadStrobeNOut) ? local_read_strobe_n : ~local_read_strobe_n);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// capture what the write strobe presents, count ack events
	always @(posedge clk_sys) begin
		if (!localWriteStrobeN) capA <= localAddress;
		if (!localWriteStrobeN) capD <= localDataOut;
		if (ackEvent) ackCnt <= ackCnt + 1;
		if (timedOut) toCnt <= toCnt + 1;
	end
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic idle();
		int i;
		i = 0;
		@(negedge clk_sys);
		while (!cmdReady && i < 3000) begin
			@(negedge clk_sys);
			i++;
		end
		if (!cmdReady) failures++;
	endtask
	task automatic send(input fpp_cmd_t c);
		@(posedge clk_sys);
		cmdValid <= 1'b1;
		cmd <= c;
		idle();
		@(posedge clk_sys);
		cmdValid <= 1'b0;
		cmd.write <= 1'b1;
		idle();
	endtask
	task automatic pull(output logic [7:0] d);
		int i;
		i = 0;
		@(posedge clk_sys);
		rspReady <= 1'b1;
		@(negedge clk_sys);
		while (!rspValid && i < 500) begin
			@(negedge clk_sys);
			i++;
		end
		if (!rspValid) failures++;
		d = rspData;
		@(posedge clk_sys);
		rspReady <= 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// cut a hang well past the expected run of under a thousand cycles
	initial begin
		#100000;
		failures++;
		conclude();
	end
	initial begin
		{rst_n, portIsParallel, lbDataStrobeStyle, parIsEpp, selectPeripheral} = 5'h00;
		{initPeripheral, autoFeed, cmdValid, rspReady, slow, irqReq, stuck} = 7'h00;
		{paperOutStatus, peripheralSelected, errorN, cmd, rdByte, local_read_strobe_n} = 36'h100000000;
		{failures, n_checks} = '0;
		rows = '{20'h13CA5, 20'h0C35A, 20'h5FF5A, 20'h40081, 20'h90081, 20'h8007E, 20'hB007E, 20'hA00E7};
		step(3);
		@(negedge clk_sys);
		check({hostSelectInN, initN, sppDataStrobeN, localWriteStrobeN, 4'h0}, 8'hF0);
		check({parallelDataOe, localDataOe, rspValid, 5'h00}, 8'h00);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		selectPeripheral <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			{portIsParallel, lbDataStrobeStyle, parIsEpp} <= {rows[i].par, rows[i].ds, rows[i].enhanced_parallel_mode};
			{rdByte, local_read_strobe_n} <= {rows[i].d, rows[i].d};
			{paperOutStatus, peripheralSelected, errorN} <= 3'(i);
			step(3);
			send('{rows[i].wr, rows[i].a, rows[i].d});
			if (!rows[i].par) check(localAddress, rows[i].a);
			if (rows[i].wr && !rows[i].par) check(capD, rows[i].d);
			if (rows[i].wr && !rows[i].par) check(capA, rows[i].a);
			if (rows[i].wr && rows[i].par) check(latched, rows[i].d);
			if (!rows[i].wr) pull(got);
			if (!rows[i].wr) check(got, rows[i].d);
			$display("row %0d done", i);
		end
		{portIsParallel, parIsEpp, lbDataStrobeStyle, local_read_strobe_n} <= 11'h011;
		send('{1'b0, 8'h01, 8'h00});
		@(posedge clk_sys);
		local_read_strobe_n <= 8'h22;
		send('{1'b0, 8'h02, 8'h00});
		@(posedge clk_sys);
		cmd.write <= 1'b0;
		step(4);
		@(negedge clk_sys);
		check({7'h00, cmdReady}, 8'h00);
		pull(got);
		check(got, 8'h11);
		pull(got);
		check(got, 8'h22);
		$display("full buffer test done");
		{portIsParallel, slow} <= 2'h3;
		n = ackCnt;
		send('{1'b1, 8'h00, 8'h3C});
		check({7'h00, status.busy}, 8'h00);
		step(10);
		check(8'(ackCnt), 8'(n + 1));
		{autoFeed, initPeripheral} <= 2'h3;
		step(3);
		@(negedge clk_sys);
		check({autoFeedNOe, autoFeedNOut, initN, 5'h00}, 8'h80);
		@(posedge clk_sys);
		{parIsEpp, irqReq} <= 2'h3;
		step(4);
		@(negedge clk_sys);
		check({autoFeedNOe, autoFeedNOut, eppIrq, 5'h00}, 8'hE0);
		send('{1'b1, 8'h00, 8'h5A});
		check(latched, 8'h5A);
		// wait never released: the closing phase must give up and flag it exactly once
		@(posedge clk_sys);
		stuck <= 1'b1;
		send('{1'b1, 8'h00, 8'hC3});
		step(2);
		stuck <= 1'b0;
		check(8'(toCnt), 8'h01);
		$display("handshake tests done");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		step(2);
		@(negedge clk_sys);
		check({hostSelectInN, initN, autoFeedNOe, rspValid, 4'h0}, 8'hC0);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		step(4);
		@(negedge clk_sys);
		check({initN, hostSelectInN, autoFeedNOe, eppIrq, cmdReady, 3'h0}, 8'h78);
		$display("reset test done");
		conclude();
	end
endmodule
bind fpp_port_core fpp_port_core_asserts chk (.*);
